/* File: dv/ccu_channel_monitor.sv */
`timescale 1ns/10ps
module ccu_channel_monitor
    import ccu_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // user port
    input wire logic start,
    input wire logic [7:0] dev_addr,
    input wire logic busy,
    input wire logic done,
    // interface pins
    input wire ccu_pkg::ccu_chan_out_t chan_o,
    input wire ccu_pkg::ccu_unit_in_t unit_i
);
    // ---------------------------------------------------------------
    // tag relations
    // ---------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // any outbound qualifying tag; the bus must not move under it
    logic tag_any;
    assign tag_any = chan_o.addr_tag | chan_o.command_tag | chan_o.service_tag;
    logic unit_tag;
    assign unit_tag = unit_i.addr_tag | unit_i.service_tag | unit_i.status_tag;

    sequence s_held;
        tag_any ##1 tag_any;
    endsequence
    sequence s_sel_up;
        chan_o.addr_tag && chan_o.select_chain && chan_o.hold_tag;
    endsequence

    property p_hold_sel;
        chan_o.hold_tag == chan_o.select_chain;
    endproperty
    property p_out_par;
        tag_any |-> ^chan_o.bus;
    endproperty
    property p_bus_stable;
        s_held |-> $stable(chan_o.bus);
    endproperty
    property p_bus_first;
        $rose(tag_any) |-> $stable(chan_o.bus);
    endproperty
    property p_start_sel;
        start && !busy |=> busy && chan_o.bus[7:0] == $past(dev_addr) ##1 s_sel_up;
    endproperty
    property p_addr_drop;
        chan_o.addr_tag && unit_i.operational |-> ##[1:4] !chan_o.addr_tag;
    endproperty
    property p_svc_cause;
        $rose(chan_o.service_tag) |->
            $past(unit_i.service_tag, 3) || $past(unit_i.status_tag, 3);
    endproperty
    property p_cmd_cause;
        $rose(chan_o.command_tag) |-> $past(unit_tag, 3);
    endproperty
    property p_cmd_drop;
        $fell(unit_tag) && chan_o.command_tag |-> ##[1:4] !chan_o.command_tag;
    endproperty
    property p_done_idle;
        done |-> !busy && !chan_o.select_chain;
    endproperty
    property p_sel_burst;
        $fell(chan_o.select_chain) |-> $past(chan_o.service_tag) || $past(chan_o.command_tag)
            || $past(unit_i.select_return, 3);
    endproperty

    a_hold_sel: assert property (p_hold_sel)
        else $error("hold and select differ");
    a_out_par: assert property (p_out_par)
        else $error("even parity on outbound bus");
    a_bus_stable: assert property (p_bus_stable)
        else $error("bus moved under tag");
    a_bus_first: assert property (p_bus_first)
        else $error("bus changed with tag");
    a_start_sel: assert property (p_start_sel)
        else $error("bad initial selection");
    a_addr_drop: assert property (p_addr_drop)
        else $error("address tag held");
    a_svc_cause: assert property (p_svc_cause)
        else $error("service without cause");
    a_cmd_cause: assert property (p_cmd_cause)
        else $error("command without cause");
    a_cmd_drop: assert property (p_cmd_drop)
        else $error("command tag held");
    a_done_idle: assert property (p_done_idle)
        else $error("done while selected");
    a_sel_burst: assert property (p_sel_burst)
        else $error("select dropped early");
endmodule : ccu_channel_monitor

bind ccu_channel ccu_channel_monitor u_mon (.clk, .reset, .start, .dev_addr, .busy, .done,
    .chan_o, .unit_i);

/* File: dv/ccu_channel_tb.sv */
`timescale 1ns/10ps
module ccu_channel_tb;
    import ccu_pkg::*;
    // ---------------------------------------------------------------
    // bench signals
    // ---------------------------------------------------------------
    localparam logic [7:0] UA = 8'h3A;
    localparam logic [7:0] CE_V = 8'h08;
    localparam logic [7:0] DE_V = 8'h04;
    logic clk = 1'b0, reset = 1'b1, start = 1'b0, wr_valid = 1'b0, slow = 1'b0, bad_par = 1'b0;
    logic [7:0] dev_addr = UA, command = 8'h01, wr_data = 8'h00;
    logic [15:0] byte_count = 16'h0000;
    logic busy, done, no_unit, parity_err, wr_ready, rx_stb;
    logic [7:0] unit_id, status_ce, status_de, rx_data, rx_cmd;
    ccu_chan_out_t chan_o;
    ccu_unit_in_t unit_i;
    int fails = 0, comparisons = 0, j;
    int seed = 32'h58a3d18b;
    logic [7:0] txq[$], rxq[$];

    always #4 clk = ~clk;

    ccu_channel dut (.clk(clk), .reset(reset), .start(start), .dev_addr(dev_addr),
        .command(command), .byte_count(byte_count), .busy(busy), .done(done),
        .no_unit(no_unit), .parity_err(parity_err), .unit_id(unit_id), .status_ce(status_ce),
        .status_de(status_de), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .chan_o(chan_o), .unit_i(unit_i));
    ccu_unit_model #(.MY_ADDR(UA), .CE(CE_V), .DE(DE_V)) unit (.clk(clk), .slow(slow),
        .bad_par(bad_par), .chan_o(chan_o), .unit_i(unit_i), .rx_data(rx_data),
        .rx_stb(rx_stb), .rx_cmd(rx_cmd));

    // collect bytes the unit took, away from the clock edge
    always @(negedge clk) if (rx_stb === 1'b1) rxq.push_back(rx_data);

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    function automatic logic odd_par(input logic [7:0] b);
        return ~^b;
    endfunction : odd_par

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    // fifo is prefilled before start so with more than four bytes it must refuse; a second start mid-run is ignored
    task automatic run(input logic [7:0] a, input int n, input logic sl, input logic bp);
        int i, k;
        logic tk, dn, pe;
        logic [7:0] cmd;
        i = 0;
        dn = 1'b0;
        cmd = 8'($random(seed));
        txq.delete();
        rxq.delete();
        for (k = 0; k < n; k++) txq.push_back(8'($random(seed)));
        @(posedge clk);
        dev_addr <= a;
        byte_count <= 16'(n);
        slow <= sl;
        bad_par <= bp;
        command <= cmd;
        for (k = 0; k < 30000 && !dn; k++) begin
            @(negedge clk);
            tk = wr_valid & wr_ready;
            dn = done;
            if (k == 6 && n > 4) chk("wr_ready", 16'h0000, {15'h0, wr_ready});
            pe = odd_par(chan_o.bus[7:0]);
            if (chan_o.command_tag === 1'b1) begin
                chk("out_par", {15'h0, pe}, {15'h0, chan_o.bus[8]});
            end
            @(posedge clk);
            if (tk) i++;
            wr_valid <= i < n;
            wr_data <= i < n ? txq[i] : 8'h00;
            start <= k == 8 || (k == 24 && a == UA);
        end
        chk("done", 16'h0001, {15'h0, dn});
        if (!dn) final_report();
        chk("no_unit", {15'h0, a != UA}, {15'h0, no_unit});
        if (a == UA) begin
            chk("unit_id", {8'h00, UA}, {8'h00, unit_id});
            chk("parity_err", {15'h0, bp}, {15'h0, parity_err});
            chk("command", {8'h00, cmd}, {8'h00, rx_cmd});
            chk("status_ce", {8'h00, CE_V}, {8'h00, status_ce});
            chk("status_de", {8'h00, DE_V}, {8'h00, status_de});
            chk("count", 16'(n), 16'(rxq.size()));
            for (k = 0; k < n && k < rxq.size(); k++) begin
                chk("data", {8'h00, txq[k]}, {8'h00, rxq[k]});
            end
        end
    endtask : run

    // reset in mid transfer must clear every outbound line
    task automatic abort_run;
        // let the unit drop out of the last selection first
        repeat (8) @(posedge clk);
        byte_count <= 16'h0002;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (40) @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(negedge clk);
        chk("reset_pins", 16'h0000, chan_o);
        chk("busy", 16'h0000, {15'h0, busy});
        // hold reset well past the edge at which select drops
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : abort_run

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        run(UA, 0, 1'b0, 1'b0);
        run(UA, 6, 1'b0, 1'b0);
        run(8'hC5, 0, 1'b0, 1'b0);
        run(UA, 3, 1'b1, 1'b1);
        for (j = 0; j < 6; j++) run(UA, $random(seed) & 15, j % 2 == 1, 1'b0);
        abort_run();
        run(UA, 5, 1'b1, 1'b0);
        final_report();
    end
endmodule : ccu_channel_tb

/* File: dv/ccu_unit_model.sv */
`timescale 1ns/10ps
module ccu_unit_model
    import ccu_pkg::*;
#(
    parameter logic [7:0] MY_ADDR = 8'h3A,
    parameter logic [7:0] CE = 8'h08,
    parameter logic [7:0] DE = 8'h04
) (
    // clock and controls
    input wire logic clk,
    input wire logic slow,
    input wire logic bad_par,
    // interface pins
    input wire ccu_pkg::ccu_chan_out_t chan_o,
    output ccu_pkg::ccu_unit_in_t unit_i,
    // what the unit received
    output logic [7:0] rx_data,
    output logic rx_stb,
    output logic [7:0] rx_cmd
);
    // ---------------------------------------------------------------
    // control unit behaviour
    // ---------------------------------------------------------------
    int st = 0;
    logic [1:0] tick = 2'h0;

    // odd parity, full byte so no unused lines
    function automatic logic [8:0] par(input logic [7:0] b);
        return {~^b, b};
    endfunction : par

    // slow mode acts one cycle in four, to stretch every interlock
    always @(posedge clk) begin
        tick <= tick + 2'h1;
        rx_stb <= 1'b0;
        if (chan_o.operational !== 1'b1) begin
            st <= 0;
            unit_i <= '0;
        end else if (!slow || tick == 2'h0) begin
            case (st)
                0: begin
                    unit_i.select_return <= chan_o.select_chain
                        && chan_o.bus[7:0] != MY_ADDR;
                    if (chan_o.select_chain && chan_o.addr_tag && chan_o.bus[7:0] == MY_ADDR) begin
                        unit_i.operational <= 1'b1;
                        st <= 1;
                    end
                end
                1: if (!chan_o.addr_tag) begin
                    unit_i.bus <= par(MY_ADDR) ^ {bad_par, 8'h00};
                    st <= 2;
                end
                2: begin
                    unit_i.addr_tag <= 1'b1;
                    st <= 3;
                end
                3: if (chan_o.command_tag) begin
                    rx_cmd <= chan_o.bus[7:0];
                    unit_i.addr_tag <= 1'b0;
                    st <= 4;
                end
                4: if (!chan_o.command_tag) begin
                    unit_i.bus <= par(8'h00);
                    st <= 5;
                end
                5, 10, 14: begin
                    unit_i.status_tag <= 1'b1;
                    st <= st + 1;
                end
                6, 11: if (chan_o.service_tag) begin
                    unit_i.status_tag <= 1'b0;
                    unit_i.bus <= ~unit_i.bus; // inverted, not left at last value
                    st <= st + 1;
                end
                7: if (!chan_o.service_tag) begin
                    unit_i.service_tag <= 1'b1;
                    st <= 8;
                end
                8: if (chan_o.service_tag) begin
                    rx_data <= chan_o.bus[7:0];
                    rx_stb <= 1'b1;
                    unit_i.service_tag <= 1'b0;
                    st <= 7;
                end else if (chan_o.command_tag) begin
                    unit_i.service_tag <= 1'b0;
                    st <= 9;
                end
                9: if (!chan_o.command_tag) begin
                    unit_i.bus <= par(CE);
                    st <= 10;
                end
                12: if (!chan_o.select_chain) begin
                    unit_i.operational <= 1'b0;
                    unit_i.request <= 1'b1;
                    st <= 13;
                end
                13: if (chan_o.select_chain) begin
                    unit_i.operational <= 1'b1;
                    unit_i.bus <= par(DE);
                    st <= 14;
                end
                15: if (chan_o.command_tag) begin
                    unit_i.status_tag <= 1'b0;
                    unit_i.request <= 1'b0;
                    unit_i.bus <= ~unit_i.bus;
                    st <= 16;
                end
                default: if (!chan_o.select_chain) begin
                    unit_i.operational <= 1'b0;
                    st <= 0;
                end
            endcase
        end
    end
endmodule : ccu_unit_model

/* File: rtl/ccu_channel.sv */
`timescale 1ns/10ps
// How it works
// - byte on bus before its qualifying tag
// - command tag qualifies command, later proceed/stop
// - channel answers with service tag
// - hold tag always rises with select
// - nine-line buses, line 0 msb, odd parity
// - narrow characters low, unused lines zero
// - burst channel keeps select high throughout
// - initial selection: address, tags, unit answers
// - unit address answered by command tag
// - unit drops address tag, channel drops command
// - zero initial status, service tag handshake
// - after last byte, command tag means stop
// - ending status, drop select, then finished status
module ccu_channel (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // user command port
    input wire logic start,
    input wire logic [7:0] dev_addr,
    input wire logic [7:0] command,
    input wire logic [ccu_pkg::CNT_W-1:0] byte_count,
    output logic busy,
    output logic done,
    output logic no_unit,
    output logic parity_err,
    output logic [7:0] unit_id,
    output logic [7:0] status_ce,
    output logic [7:0] status_de,
    // user write data
    input wire logic [ccu_pkg::FIFO_W-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    // interface pins
    output ccu_pkg::ccu_chan_out_t chan_o,
    input wire ccu_pkg::ccu_unit_in_t unit_i
);
    import ccu_pkg::*;

    // ---------------------------------------------------------------
    // state record
    // ---------------------------------------------------------------
    // unit lines, outbound pins and sequencer share one record
    typedef struct packed {
        ccu_unit_in_t s1;
        ccu_unit_in_t s2;
        ccu_chan_out_t o;
        ccu_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [7:0] ce;
        logic [7:0] de;
        logic [7:0] uid;
        logic perr;
        logic nounit;
        logic done;
    } ccu_st_t;

    ccu_st_t st_ff;
    ccu_st_t nxt_st;
    ccu_unit_in_t u;
    logic [FIFO_W-1:0] fifo_data;
    logic fifo_valid;
    logic take;

    // odd parity bit over one byte
    function automatic logic odd_par(input logic [7:0] b);
        odd_par = ~^b;
    endfunction : odd_par

    // nine-line bus word: parity on top, line 0 in bit 7
    function automatic logic [8:0] bus_word(input logic [7:0] b);
        bus_word = {odd_par(b), b};
    endfunction : bus_word

    // true when a received word fails the odd parity check
    function automatic logic bad_par(input logic [8:0] w);
        bad_par = (w[PAR_POS] != odd_par(w[7:0]));
    endfunction : bad_par

    // ---------------------------------------------------------------
    // write data buffer
    // ---------------------------------------------------------------
    // a user without data just stalls the unit's service request
    ccu_fifo #(
        .W(FIFO_W),
        .D(FIFO_D)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_data(wr_data),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(take)
    );

    // synchronised view of the unit lines; s1 only feeds s2, everything else reads s2
    assign u = st_ff.s2;

    // a byte leaves the buffer when the unit asks and one is owed
    // the count check keeps back a byte that the stop answer would lose
    assign take = (st_ff.state == S_DATA) && u.service_tag
        && (st_ff.cnt != CNT_ZERO) && fifo_valid;

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // every pin comes straight from a flop, so no glitch reaches the cable
    assign chan_o = st_ff.o;
    assign busy = (st_ff.state != S_IDLE);
    assign done = st_ff.done;
    assign no_unit = st_ff.nounit;
    assign parity_err = st_ff.perr;
    assign unit_id = st_ff.uid;
    assign status_ce = st_ff.ce;
    assign status_de = st_ff.de;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    // each wait looks for the opposite of the last level seen, so
    // the two-cycle sync lag can never double a handshake step
    always_comb begin
        nxt_st = st_ff;
        // two flops on every unit line; the cable is not on our clock
        nxt_st.s1 = unit_i;
        nxt_st.s2 = st_ff.s1;
        nxt_st.done = 1'b0;
        // operational held high, suppress never used here
        nxt_st.o.operational = 1'b1;
        nxt_st.o.suppress = 1'b0;
        case (st_ff.state)
            S_IDLE: begin
                // address goes out a clock before any tag rises
                if (start) begin
                    nxt_st.o.bus = bus_word(dev_addr);
                    nxt_st.cnt = byte_count;
                    nxt_st.perr = 1'b0;
                    nxt_st.nounit = 1'b0;
                    nxt_st.state = S_SEL;
                end
            end
            S_SEL: begin
                // address already on the bus one edge earlier
                // operational is only trusted once select has stood a cycle
                nxt_st.o.addr_tag = 1'b1;
                nxt_st.o.hold_tag = 1'b1;
                nxt_st.o.select_chain = 1'b1;
                if (st_ff.o.select_chain && u.operational) begin
                    nxt_st.o.addr_tag = 1'b0;
                    nxt_st.state = S_UADR;
                end else if (st_ff.o.select_chain && u.select_return) begin
                    // select ran round the loop: nobody took it
                    nxt_st.o.addr_tag = 1'b0;
                    nxt_st.o.hold_tag = 1'b0;
                    nxt_st.o.select_chain = 1'b0;
                    nxt_st.nounit = 1'b1;
                    nxt_st.done = 1'b1;
                    nxt_st.state = S_IDLE;
                end
            end
            S_UADR: begin
                // unit identity is only valid while its tag is up
                if (u.addr_tag) begin
                    nxt_st.uid = u.bus[7:0];
                    nxt_st.perr = st_ff.perr | bad_par(u.bus);
                    nxt_st.o.bus = bus_word(command);
                    nxt_st.state = S_CMD;
                end
            end
            S_CMD: begin
                // command byte already stands on the bus from the last step
                nxt_st.o.command_tag = 1'b1;
                if (st_ff.o.command_tag && !u.addr_tag) begin
                    nxt_st.o.command_tag = 1'b0;
                    nxt_st.state = S_IST;
                end
            end
            S_IST: begin
                // initial status byte is parity checked only, not judged
                if (u.status_tag) begin
                    nxt_st.perr = st_ff.perr | bad_par(u.bus);
                    nxt_st.o.service_tag = 1'b1;
                    nxt_st.state = S_IST_DN;
                end
            end
            S_IST_DN: begin
                // service stays up until the unit lets go of status
                if (!u.status_tag) begin
                    nxt_st.o.service_tag = 1'b0;
                    nxt_st.state = S_DATA;
                end
            end
            S_DATA: begin
                // select stays up for the whole burst
                // an empty buffer just leaves the unit's request waiting
                if (u.service_tag && (st_ff.cnt == CNT_ZERO)) begin
                    nxt_st.o.command_tag = 1'b1;
                    nxt_st.state = S_STOP;
                end else if (take) begin
                    nxt_st.o.bus = bus_word(fifo_data);
                    nxt_st.cnt = st_ff.cnt - CNT_ONE;
                    nxt_st.state = S_DTAG;
                end
            end
            S_DTAG: begin
                // byte went onto the bus the edge before this tag
                // tag comes down only after the unit has taken the byte
                nxt_st.o.service_tag = 1'b1;
                if (st_ff.o.service_tag && !u.service_tag) begin
                    nxt_st.o.service_tag = 1'b0;
                    nxt_st.state = S_DATA;
                end
            end
            S_STOP: begin
                // stop stands until the unit drops its service request
                if (!u.service_tag) begin
                    nxt_st.o.command_tag = 1'b0;
                    nxt_st.state = S_END;
                end
            end
            S_END: begin
                // hold and select stay up through the channel end status
                if (u.status_tag) begin
                    nxt_st.ce = u.bus[7:0];
                    nxt_st.perr = st_ff.perr | bad_par(u.bus);
                    nxt_st.o.service_tag = 1'b1;
                    nxt_st.state = S_END_DN;
                end
            end
            S_END_DN: begin
                if (!u.status_tag) begin
                    nxt_st.o.service_tag = 1'b0;
                    nxt_st.o.hold_tag = 1'b0;
                    nxt_st.o.select_chain = 1'b0;
                    // parked bus keeps odd parity: the later proceed tag
                    // qualifies whatever word stands here
                    nxt_st.o.bus = bus_word(BYTE_ZERO);
                    nxt_st.state = S_OFF;
                end
            end
            S_OFF: begin
                // unit leaves the selection; then it must ask again
                if (!u.operational) begin
                    nxt_st.state = S_DE;
                end
            end
            S_DE: begin
                // finished status comes in its own status sequence
                // no address exchange here; the unit is known already
                if (u.request) begin
                    nxt_st.o.hold_tag = 1'b1;
                    nxt_st.o.select_chain = 1'b1;
                end
                if (st_ff.o.select_chain && u.status_tag) begin
                    nxt_st.de = u.bus[7:0];
                    nxt_st.perr = st_ff.perr | bad_par(u.bus);
                    nxt_st.o.command_tag = 1'b1;
                    nxt_st.state = S_DE_DN;
                end
            end
            S_DE_DN: begin
                // proceed stands until the unit releases its status
                if (!u.status_tag) begin
                    nxt_st.o.command_tag = 1'b0;
                    nxt_st.o.hold_tag = 1'b0;
                    nxt_st.o.select_chain = 1'b0;
                    nxt_st.done = 1'b1;
                    nxt_st.state = S_IDLE;
                end
            end
            default: begin
                // unused codes fall back to idle rather than lock up
                nxt_st.state = S_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // operational reads low during reset, resetting attached units
    // one register for the whole record keeps all fields on one edge
    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : ccu_channel

/* File: rtl/ccu_fifo.sv */
`timescale 1ns/10ps
module ccu_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_ff [D];
    logic [AW:0] wp_ff;
    logic [AW:0] rp_ff;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty
    assign empty = (wp_ff == rp_ff);
    assign full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_ff[rp_ff[AW-1:0]];

    // pointers and storage
    always_ff @(posedge clk) begin
        if (reset) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (in_valid && !full) begin
                mem_ff[wp_ff[AW-1:0]] <= in_data;
                wp_ff <= wp_ff + 1'b1;
            end
            if (out_ready && !empty) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end
endmodule : ccu_fifo

/* File: rtl/ccu_pkg.sv */
package ccu_pkg;
    // ---------------------------------------------------------------
    // widths and sizes
    // ---------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int BUS_W = 9;
    localparam int PAR_POS = 8;
    localparam int CNT_W = 16;
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 4;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // ---------------------------------------------------------------
    // pin groups
    // ---------------------------------------------------------------
    // channel to units; bus bit 7 is line 0 (msb), bit 8 parity
    typedef struct packed {
        logic [8:0] bus;
        logic addr_tag;
        logic command_tag;
        logic service_tag;
        logic hold_tag;
        logic select_chain;
        logic operational;
        logic suppress;
    } ccu_chan_out_t;

    // units to channel
    typedef struct packed {
        logic [8:0] bus;
        logic addr_tag;
        logic status_tag;
        logic service_tag;
        logic operational;
        logic select_return;
        logic request;
    } ccu_unit_in_t;

    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_SEL = 4'h1,
        S_UADR = 4'h2,
        S_CMD = 4'h3,
        S_IST = 4'h4,
        S_IST_DN = 4'h5,
        S_DATA = 4'h6,
        S_DTAG = 4'h7,
        S_STOP = 4'h8,
        S_END = 4'h9,
        S_END_DN = 4'hA,
        S_OFF = 4'hB,
        S_DE = 4'hC,
        S_DE_DN = 4'hD
    } ccu_state_t;
endpackage : ccu_pkg
